// [hw/b4reg_defines.vh]
// register offsets, field positions and reset values of the fourth buck control set
`ifndef B4REG_DEFINES_VH
`define B4REG_DEFINES_VH
`define B4_ADDR_CONTROL 8'hBD
`define B4_ADDR_SLOTS 8'hBE
`define B4_ADDR_LOWPWR 8'hBF
`define B4_OVP_OFF_BIT 11
`define B4_FLOAT_BIT 10
`define B4_VSEL_MSB 6
`define B4_FAULT_MSB 15
`define B4_FAULT_LSB 14
`define B4_ENSLOT_MSB 13
`define B4_ENSLOT_LSB 10
`define B4_SDSLOT_MSB 9
`define B4_SDSLOT_LSB 6
`define B4_HIB_MSB 14
`define B4_HIB_LSB 12
`define B4_TRIG_MSB 9
`define B4_TRIG_LSB 8
`define B4_VIMG_RESET 7'h06
`define B4_VCODE_MAX 7'h66
`define B4_SLOT_NONE 4'h0
`define B4_SLOT_ACTIVE 4'hF
`define B4_FAULT_IGNORE 2'h0
`define B4_FAULT_CONV 2'h1
`define B4_HIB_KEEP 3'h0
`define B4_HIB_IMG 3'h1
`define B4_HIB_STBY 3'h2
`define B4_HIB_STBY_IMG 3'h3
`define B4_HIB_LDO 3'h4
`define B4_HIB_LDO_IMG 3'h5
`define B4_HIB_OFF 3'h7
`endif

// [hw/b4reg_control_regs.v]
// fourth buck regulator control registers and their decoded controls
`timescale 1ns/1ps
`include "b4reg_defines.vh"

// Contract
// - bit 11 set disables overvoltage protection
// - bit 10 set floats output when disabled
// - seven-bit code, 25mV steps from 0.85V
// - listed codes map to listed voltages
// - fault always interrupts, action per field
// - fault action 11 means system shutdown; code shuts down on 10 as well (bit 15 alone)
// - start-up in slots one to fourteen
// - start-up slot zero never starts
// - start-up slot fifteen starts entering active
// - shutdown slots; zero/fifteen wait for off
// - sleep codes 000 to 011 behaviours
// - codes 100/101 linear, 111 off, 110 reserved
// - trigger select picks sleep source
// - hibernate pin input always also triggers
// - alternate code 7 bits, resets 0000110
// - state machine reset restores defaults
module b4reg_control_regs #(
	parameter [6:0] VSEL_RESET = 7'h00,
	parameter [3:0] ENSLOT_RESET = 4'h0,
	parameter [6:0] VIMG_RESET = `B4_VIMG_RESET
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	input wire smResetReq,
	// register port
	input wire [7:0] regAddr,
	input wire regWrite,
	input wire [15:0] regWdata,
	output reg [15:0] regRdata,
	// sequencer and state machine
	input wire [3:0] currentSlot,
	input wire startupPhase,
	input wire shutdownPhase,
	input wire enterActive,
	input wire enterOff,
	input wire softSleepRequest,
	input wire low_power_input_one,
	input wire low_power_input_two,
	input wire low_power_input_three,
	input wire gpioSleepInput,
	input wire converterFault,
	// converter and system controls
	output reg overvoltage_protect_off,
	output reg output_float_on_disable,
	output reg [6:0] appliedVoltageCode,
	output reg converterEnable,
	output reg standbyForce,
	output reg linearForce,
	output reg faultInterrupt,
	output reg systemShutdown
);
	localparam PINS = 5;
	localparam PIN_HIBERNATE = 4;

	reg rstSync1, rstSync2;
	wire rstInt_n;
	reg ovpOff_reg, float_reg;
	reg [6:0] vsel_reg, vimg_reg;
	reg [1:0] fault_reg;
	reg [3:0] enSlot_reg, sdSlot_reg;
	reg [2:0] hib_reg;
	reg [1:0] trig_reg;
	wire [PINS-1:0] pinRaw;
	wire [PINS-1:0] pinSync;
	wire writeControl, writeSlots, writeLowPower;
	reg sleeping, faultOff;
	reg startHit, activeHit, stopHit;
	reg enable_reg, enable_next;
	reg [6:0] codeSel;
	reg ovpOff_next, float_next;
	reg [6:0] appliedCode_next;
	reg converterEnable_next, standbyForce_next, linearForce_next;
	reg faultInterrupt_next, systemShutdown_next;

	function [6:0] clampCode;
		input [6:0] code;
		begin
			clampCode = (code > `B4_VCODE_MAX) ? `B4_VCODE_MAX : code;
		end
	endfunction

	function useImage;
		input [2:0] mode;
		begin
			useImage = (mode == `B4_HIB_IMG) || (mode == `B4_HIB_STBY_IMG) ||
				(mode == `B4_HIB_LDO_IMG);
		end
	endfunction

	function isStandby;
		input [2:0] mode;
		begin
			isStandby = (mode == `B4_HIB_STBY) || (mode == `B4_HIB_STBY_IMG);
		end
	endfunction

	function isLinear;
		input [2:0] mode;
		begin
			isLinear = (mode == `B4_HIB_LDO) || (mode == `B4_HIB_LDO_IMG);
		end
	endfunction

	// slots 1..14 only; 0 and 15 are handled as special cases
	function isNumberedSlot;
		input [3:0] slot;
		begin
			isNumberedSlot = (slot != `B4_SLOT_NONE) && (slot != `B4_SLOT_ACTIVE);
		end
	endfunction

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	assign rstInt_n = rstSync2;

	assign writeControl = regWrite && (regAddr == `B4_ADDR_CONTROL);
	assign writeSlots = regWrite && (regAddr == `B4_ADDR_SLOTS);
	assign writeLowPower = regWrite && (regAddr == `B4_ADDR_LOWPWR);

	// pins: sleep request, three low-power inputs, hibernate pin
	assign pinRaw = {gpioSleepInput, low_power_input_three, low_power_input_two,
		low_power_input_one, softSleepRequest};

	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1) begin : gSync
			reg stage1, stage2;
			always @(posedge ref_clk or negedge rstInt_n) begin
				if (!rstInt_n) begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end else begin
					stage1 <= pinRaw[g];
					stage2 <= stage1;
				end
			end
			assign pinSync[g] = stage2;
		end
	endgenerate

	// control word: protection, discharge, voltage code
	always @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			ovpOff_reg <= 1'b0;
			float_reg <= 1'b0;
			vsel_reg <= VSEL_RESET;
		end else if (smResetReq) begin
			ovpOff_reg <= 1'b0;
			float_reg <= 1'b0;
			vsel_reg <= VSEL_RESET;
		end else if (writeControl) begin
			ovpOff_reg <= regWdata[`B4_OVP_OFF_BIT];
			float_reg <= regWdata[`B4_FLOAT_BIT];
			vsel_reg <= regWdata[`B4_VSEL_MSB:0];
		end
	end

	// slot word: fault action, start-up and shutdown slots
	always @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			fault_reg <= 2'h0;
			enSlot_reg <= ENSLOT_RESET;
			sdSlot_reg <= 4'h0;
		end else if (smResetReq) begin
			fault_reg <= 2'h0;
			enSlot_reg <= ENSLOT_RESET;
			sdSlot_reg <= 4'h0;
		end else if (writeSlots) begin
			fault_reg <= regWdata[`B4_FAULT_MSB:`B4_FAULT_LSB];
			enSlot_reg <= regWdata[`B4_ENSLOT_MSB:`B4_ENSLOT_LSB];
			sdSlot_reg <= regWdata[`B4_SDSLOT_MSB:`B4_SDSLOT_LSB];
		end
	end

	// low-power word: sleep behaviour, trigger, alternate code
	always @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			hib_reg <= 3'h0;
			trig_reg <= 2'h0;
			vimg_reg <= VIMG_RESET;
		end else if (smResetReq) begin
			hib_reg <= 3'h0;
			trig_reg <= 2'h0;
			vimg_reg <= VIMG_RESET;
		end else if (writeLowPower) begin
			hib_reg <= regWdata[`B4_HIB_MSB:`B4_HIB_LSB];
			trig_reg <= regWdata[`B4_TRIG_MSB:`B4_TRIG_LSB];
			vimg_reg <= regWdata[`B4_VSEL_MSB:0];
		end
	end

	// reserved bits read as zero
	always @* begin
		case (regAddr)
		`B4_ADDR_CONTROL: begin
			regRdata = {4'h0, ovpOff_reg, float_reg, 3'h0, vsel_reg};
		end
		`B4_ADDR_SLOTS: begin
			regRdata = {fault_reg, enSlot_reg, sdSlot_reg, 6'h00};
		end
		`B4_ADDR_LOWPWR: begin
			regRdata = {1'b0, hib_reg, 2'h0, trig_reg, 1'b0, vimg_reg};
		end
		default: begin
			regRdata = 16'h0000;
		end
		endcase
	end

	// sleep source select plus hibernate pin
	always @* begin
		sleeping = pinSync[trig_reg] | pinSync[PIN_HIBERNATE];
		faultOff = converterFault && (fault_reg != `B4_FAULT_IGNORE);
		codeSel = (sleeping && useImage(hib_reg)) ? vimg_reg : vsel_reg;
		startHit = startupPhase && isNumberedSlot(enSlot_reg) &&
			(enSlot_reg == currentSlot);
		activeHit = enterActive && (enSlot_reg == `B4_SLOT_ACTIVE);
		stopHit = shutdownPhase && isNumberedSlot(sdSlot_reg) &&
			(sdSlot_reg == currentSlot);
		// later tests win: fault over off over slot over start
		enable_next = enable_reg;
		if (startHit || activeHit) begin
			enable_next = 1'b1;
		end
		if (stopHit) begin
			enable_next = 1'b0;
		end
		if (enterOff) begin
			enable_next = 1'b0;
		end
		if (faultOff) begin
			enable_next = 1'b0;
		end
	end

	// next values of the registered controls
	always @* begin
		ovpOff_next = ovpOff_reg;
		float_next = float_reg;
		appliedCode_next = clampCode(codeSel);
		converterEnable_next = enable_next && !(sleeping && hib_reg == `B4_HIB_OFF);
		standbyForce_next = sleeping && isStandby(hib_reg);
		linearForce_next = sleeping && isLinear(hib_reg);
		faultInterrupt_next = converterFault;
		systemShutdown_next = converterFault && fault_reg[1];
	end

	// state machine reset drops the held enable
	always @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			enable_reg <= 1'b0;
		end else if (smResetReq) begin
			enable_reg <= 1'b0;
		end else begin
			enable_reg <= enable_next;
		end
	end

	always @(posedge ref_clk or negedge rstInt_n) begin
		if (!rstInt_n) begin
			overvoltage_protect_off <= 1'b0;
			output_float_on_disable <= 1'b0;
			appliedVoltageCode <= 7'h00;
			converterEnable <= 1'b0;
			standbyForce <= 1'b0;
			linearForce <= 1'b0;
			faultInterrupt <= 1'b0;
			systemShutdown <= 1'b0;
		end else begin
			overvoltage_protect_off <= ovpOff_next;
			output_float_on_disable <= float_next;
			appliedVoltageCode <= appliedCode_next;
			converterEnable <= converterEnable_next;
			standbyForce <= standbyForce_next;
			linearForce <= linearForce_next;
			faultInterrupt <= faultInterrupt_next;
			systemShutdown <= systemShutdown_next;
		end
	end
endmodule // b4reg_control_regs

// [bench/b4reg_control_regs_assertions.sv]
// concurrent checks on the fourth buck control register ports
`timescale 1ns/1ps
module b4reg_control_regs_assertions (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	input wire smResetReq,
	// register port
	input wire [7:0] regAddr,
	input wire regWrite,
	input wire [15:0] regWdata,
	input wire [15:0] regRdata,
	// state machine and converter
	input wire enterOff,
	input wire converterFault,
	input wire overvoltage_protect_off,
	input wire output_float_on_disable,
	input wire [6:0] appliedVoltageCode,
	input wire converterEnable,
	input wire faultInterrupt,
	input wire systemShutdown
);
	reg [1:0] up;
	// internal reset lags the pin by two edges
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (up != 2'h3);
	property p_irq; converterFault |=> faultInterrupt; endproperty
	a_irq: assert property (p_irq) else $error("fault gave no interrupt");
	property p_sys; systemShutdown |-> $past(converterFault); endproperty
	a_sys: assert property (p_sys) else $error("shutdown without fault");
	property p_bits; regWrite && regAddr == 8'hBD && !smResetReq |=> ##1
		{overvoltage_protect_off, output_float_on_disable} == $past(regWdata[11:10], 2); endproperty
	a_bits: assert property (p_bits) else $error("control bits wrong");
	property p_clamp; appliedVoltageCode <= 7'h66; endproperty
	a_clamp: assert property (p_clamp) else $error("code above maximum");
	property p_img; regWrite && regAddr == 8'hBF && !smResetReq ##1 regAddr == 8'hBF
		|-> regRdata[6:0] == $past(regWdata[6:0]); endproperty
	a_img: assert property (p_img) else $error("image code readback");
	property p_sm; smResetReq ##1 regAddr == 8'hBF |-> regRdata == 16'h0006; endproperty
	a_sm: assert property (p_sm) else $error("state reset missed");
	property p_off; enterOff |=> !converterEnable; endproperty
	a_off: assert property (p_off) else $error("still on after off");
	property p_map; regAddr < 8'hBD || regAddr > 8'hBF |-> regRdata == 16'h0000; endproperty
	a_map: assert property (p_map) else $error("unmapped read nonzero");
	c_fault: cover property (converterFault ##1 systemShutdown);
	c_off: cover property (enterOff);
	c_wr: cover property (regWrite && regAddr == 8'hBD);
endmodule // b4reg_control_regs_assertions
bind b4reg_control_regs b4reg_control_regs_assertions CHK (.*);

// [bench/b4reg_sequencer.sv]
// slot sequencer model driving the phases and state entries
`timescale 1ns/1ps
module b4reg_sequencer (
	// clock and requests
	input wire ref_clk,
	input wire goUp,
	input wire goDown,
	// slot outputs
	output reg [3:0] currentSlot = 4'h0,
	output reg startupPhase = 1'h0,
	output reg shutdownPhase = 1'h0,
	output reg enterActive = 1'h0,
	output reg enterOff = 1'h0
);
	always @(posedge ref_clk) begin
		enterActive <= startupPhase && currentSlot == 4'hE;
		enterOff <= shutdownPhase && currentSlot == 4'hE;
		if (goUp || goDown) {startupPhase, shutdownPhase, currentSlot} <= {goUp, goDown, 4'h1};
		else if (currentSlot == 4'hE || currentSlot == 4'h0) {startupPhase, shutdownPhase,
			currentSlot} <= 6'h00;
		else currentSlot <= currentSlot + 4'h1;
	end
endmodule // b4reg_sequencer

// [bench/b4reg_control_regs_test.sv]
// self-checking bench for the fourth buck control registers
`timescale 1ns/1ps
module b4reg_control_regs_test;
	reg ref_clk = 0, rst_n = 0, smResetReq = 0, regWrite = 0, goUp = 0, goDown = 0;
	reg softSleepRequest = 0, gpioSleepInput = 0, converterFault = 0, low_power_input_one = 0;
	reg low_power_input_two = 0, low_power_input_three = 0;
	reg [7:0] regAddr = 0, a;
	reg [15:0] regWdata = 0, rnd;
	reg [6:0] vt [0:8] = '{7'h00, 7'h06, 7'h0E, 7'h26, 7'h4E, 7'h56, 7'h62, 7'h66, 7'h7F};
	reg [3:0] ks [0:3] = '{4'h0, 4'h5, 4'hE, 4'hF};
	wire [15:0] regRdata;
	wire [6:0] appliedVoltageCode;
	wire [3:0] currentSlot;
	wire startupPhase, shutdownPhase, enterActive, enterOff, overvoltage_protect_off;
	wire output_float_on_disable, converterEnable, standbyForce, linearForce;
	wire faultInterrupt, systemShutdown;
	int bad_count = 0, compares = 0, i;
	b4reg_control_regs #(.VSEL_RESET(7'h56), .ENSLOT_RESET(4'h3)) DUT (.*);
	b4reg_sequencer SEQ (.*);
	initial forever #10 ref_clk = ~ref_clk;
	function [15:0] mask(input [7:0] x);
		mask = x == 8'hBD ? 16'h0C7F : x == 8'hBE ? 16'hFFC0 : x == 8'hBF ? 16'h737F : 16'h0;
	endfunction
	task chk(input [15:0] seen, input [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n); repeat (n) @(negedge ref_clk); endtask
	task wr(input [7:0] x, input [15:0] d);
		@(negedge ref_clk) {regAddr, regWdata, regWrite} = {x, d, 1'b1};
		@(negedge ref_clk) regWrite = 0;
	endtask
	task rd(input [7:0] x, input [15:0] e);
		@(negedge ref_clk) regAddr = x;
		#1 chk(regRdata, e);
	endtask
	task go(input u);
		@(negedge ref_clk) {goUp, goDown} = {u, !u};
		@(negedge ref_clk) {goUp, goDown} = 2'h0;
	endtask
	task conclude;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#1000000 bad_count++;
		conclude;
	end
	initial begin
		rnd = 16'($urandom(32'h7A8E03F0));
		cyc(10);
		rst_n = 1;
		cyc(4);
		rd(8'hBD, 16'h0056);
		rd(8'hBE, 16'h0C00);
		rd(8'hBF, 16'h0006);
		for (i = 0; i < 12; i++) begin
			rnd = 16'($urandom);
			a = 8'hBD + 8'(i % 4);
			wr(a, rnd);
			rd(a, rnd & mask(a));
		end
		wr(8'hBD, 16'h0C66);
		cyc(2);
		chk({overvoltage_protect_off, output_float_on_disable}, 2'h3);
		wr(8'hBD, 16'h0000);
		cyc(2);
		chk({overvoltage_protect_off, output_float_on_disable}, 2'h0);
		foreach (vt[j]) begin
			wr(8'hBD, {9'h0, vt[j]});
			cyc(2);
			chk(appliedVoltageCode, vt[j] > 7'h66 ? 7'h66 : vt[j]);
		end
		foreach (ks[j]) begin
			wr(8'hBE, {2'h0, ks[j], 10'h0});
			go(0); cyc(20); chk(converterEnable, 0);
			go(1); cyc(20); chk(converterEnable, ks[j] != 0);
		end
		wr(8'hBE, 16'h3D40);
		go(1); cyc(20); go(0); cyc(8); chk(converterEnable, 0);
		for (i = 0; i < 4; i++) begin
			wr(8'hBE, {2'(i), 14'h3C00});
			go(1); cyc(20);
			@(negedge ref_clk) converterFault = 1;
			@(negedge ref_clk) converterFault = 0;
			chk(faultInterrupt, 1);
			chk(systemShutdown, i > 1);
			chk(converterEnable, i == 0);
		end
		wr(8'hBF, 16'h1122);
		low_power_input_one = 1; cyc(5); chk(appliedVoltageCode, 7'h22);
		wr(8'hBF, 16'h4022);
		low_power_input_one = 0; gpioSleepInput = 1; cyc(5); chk(linearForce, 1);
		chk(standbyForce, 0);
		wr(8'hBF, 16'h2000);
		gpioSleepInput = 0; softSleepRequest = 1; cyc(5); chk(standbyForce, 1);
		chk(linearForce, 0);
		softSleepRequest = 0; cyc(5); chk(standbyForce, 0);
		@(negedge ref_clk) smResetReq = 1;
		@(negedge ref_clk) smResetReq = 0;
		rd(8'hBF, 16'h0006);
		rd(8'hBE, 16'h0C00);
		conclude;
	end
endmodule // b4reg_control_regs_test
